// [design/tpbc_regs.svh]
/*
 Register offsets, field positions, reset values and the external-clock prescaler code of the
 four-channel timer with buffered pulse-width pairs.
 Assumes inclusion by bare name from the timer module.
*/
// Behaviour
// R1 - Channel 0 buffer bit links pair 01
// R2 - Channel 2 buffer bit links pair 23
// R3 - First set initially; second write takes next period
// R4 - Each wrap selects last written value set
// R5 - Second channel control unused, pin released
// R6 - Software avoids writing active value set
// R7 - Software: stop, reset, period, width, control, run
// R8 - Mode pair 01 unbuffered, 10 buffered
// R9 - Level pair 10 clears, 11 sets
// R10 - Software never toggles on compare in PWM
// R11 - Buffer bit overrides unbuffered mode bit
// R12 - No wrap toggle gives 0% duty
// R13 - Full duty force with no toggle 100%
// R14 - Wrap flag at limit; request only if enabled
// R15 - Channel flag on event; request if enabled
// R16 - Wait keeps running, registers blocked, requests wake
// R17 - Stop halts, keeps all state; code stops only counter and prescaler, captures and flag setting still act
// R18 - Break freezes counter
// R19 - Break without clear enable protects flags
// R20 - Break with clear enable, clears stick
// R21 - Prescale all ones selects external clock
// R22 - External clock at most bus over 2
// R23 - External pin input when selected, else port
// R24 - Each channel capture or compare independently
// R25 - Codes 0 to 6 divide 1 to 64
// R26 - Counter reset clears counter, prescaler, self-clears
// R27 - Counter at limit wraps to zero next tick
// R28 - Per-pair last-written flag sampled at wrap
// R29 - Stop with reset holds counter at zero
`ifndef TPBC_REGS_SVH
`define TPBC_REGS_SVH
`define TPBC_ADDR_W        5
`define TPBC_A_CTRL        5'h00
`define TPBC_A_CNT         5'h01
`define TPBC_A_LIMIT       5'h02
`define TPBC_A_CHCTL0      5'h04
`define TPBC_A_CHVAL0      5'h08
`define TPBC_A_PIN         5'h0C
`define TPBC_F_PS_LO       0
`define TPBC_F_RST         4
`define TPBC_F_HALT        5
`define TPBC_F_WIE         6
`define TPBC_F_WFLAG       7
`define TPBC_F_MAX         0
`define TPBC_F_TOV         1
`define TPBC_F_ELSA        2
`define TPBC_F_ELSB        3
`define TPBC_F_MSA         4
`define TPBC_F_MSB         5
`define TPBC_F_CIE         6
`define TPBC_F_CFLAG       7
`define TPBC_PS_EXT        3'h7
`define TPBC_LIMIT_RST     16'hFFFF
`define TPBC_CTRL_RST      8'h20
`endif

// [design/tpbc_pkg.sv]
/*
 Types of the timer block.
 Assumes the register header sits beside it.
*/
package tpbc_pkg;
    typedef logic [15:0] tpbc_word_t;
    typedef logic [7:0]  tpbc_byte_t;
endpackage : tpbc_pkg

// [design/tpbc_timer.sv]
/*
 Four-channel timer: counter with prescaler or external clock, compare and
 capture channels, buffered PWM pairs, wrap and channel flags.
 Assumes a plain register port on ref_clk and pins sampled from outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tpbc_regs.svh"
module tpbc_timer #(
    parameter int NCH = 4
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic [4:0]          addr,
    input  wire tpbc_pkg::tpbc_word_t wdata,
    input  wire logic                wr_stb,
    input  wire logic                rd_stb,
    output logic     [15:0]          rdata,
    input  wire logic                wait_mode,
    input  wire logic                stop_mode,
    input  wire logic                break_state,
    input  wire logic                break_clear_enable,
    input  wire logic                ext_count_clock_pin,
    input  wire logic [3:0]          ch_pin_in,
    output logic     [3:0]           ch_pin_out,
    output logic     [3:0]           ch_pin_oe,
    output logic                     ext_clk_selected,
    output logic                     irq_req
);
    import tpbc_pkg::*;

    initial begin
        if (NCH != 4) $error("NCH must be 4");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    tpbc_byte_t ctrl_r;
    tpbc_word_t cnt_r;
    tpbc_word_t limit_r;
    tpbc_byte_t chctl_r [4];
    tpbc_word_t chval_r [4];
    logic [1:0] last_wr_r;
    logic [1:0] active_r;
    logic [5:0] pre_r;
    logic [1:0] ext_sync_r;
    logic       ext_prev_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_prev_r;
    logic       wflag_armed_r;
    logic [3:0] cflag_armed_r;
    logic [3:0] out_r;
    logic [15:0] rdata_r;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_buffered(input logic [1:0] ch, input tpbc_byte_t c0,
                                         input tpbc_byte_t c2);
        is_buffered = (ch < 2'd2) ? c0[`TPBC_F_MSB] : c2[`TPBC_F_MSB];
    endfunction : is_buffered

    function automatic logic is_compare(input tpbc_byte_t c);
        is_compare = c[`TPBC_F_MSB] | c[`TPBC_F_MSA]; // R8 R11
    endfunction : is_compare

    // Wait blocks register access
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = wr_stb & ~wait_mode; // R16
    assign rd_ok = rd_stb & ~wait_mode; // R16

    // ----------------------------------------
    // Counter clock
    // ----------------------------------------
    logic [2:0] ps;
    logic       tick;
    logic       run;
    logic       ext_sel;
    logic       pre_tick;
    logic       wrap;
    assign ps      = ctrl_r[2:0];
    assign ext_sel = (ps == `TPBC_PS_EXT); // R21
    // Halt, stop and break freeze the counter
    assign run     = ~ctrl_r[`TPBC_F_HALT] & ~stop_mode & ~break_state; // R17 R18
    always_comb begin
        unique case (ps)
            3'h0: pre_tick = 1'b1; // R25
            3'h1: pre_tick = (pre_r[0] == 1'b1);
            3'h2: pre_tick = (pre_r[1:0] == 2'h3);
            3'h3: pre_tick = (pre_r[2:0] == 3'h7);
            3'h4: pre_tick = (pre_r[3:0] == 4'hF);
            3'h5: pre_tick = (pre_r[4:0] == 5'h1F);
            3'h6: pre_tick = (pre_r == 6'h3F);
            default: pre_tick = ext_sync_r[1] & ~ext_prev_r; // R21
        endcase
    end
    assign tick = run & pre_tick;
    assign wrap = tick & (cnt_r == limit_r); // R27
    // Count the tick moves to; compare acts as the counter reaches the width
    tpbc_word_t cnt_nxt;
    assign cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;

    logic rst_req;
    assign rst_req = wr_ok & (addr == `TPBC_A_CTRL) & wdata[`TPBC_F_RST];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_sync_r <= 2'b00;
            ext_prev_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], ext_count_clock_pin};
            ext_prev_r <= ext_sync_r[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pre_r <= 6'h00;
            cnt_r <= 16'h0000;
        end else if (rst_req) begin
            pre_r <= 6'h00; // R26 R29
            cnt_r <= 16'h0000; // R26 R29
        end else begin
            if (run) pre_r <= pre_r + 6'h01;
            if (wrap) cnt_r <= 16'h0000; // R27
            else if (tick) cnt_r <= cnt_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // Timer control and limit
    // ----------------------------------------
    logic ctrl_rd;
    assign ctrl_rd = rd_ok & (addr == `TPBC_A_CTRL);
    logic clr_allow;
    assign clr_allow = ~break_state | break_clear_enable; // R19 R20

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r        <= `TPBC_CTRL_RST;
            wflag_armed_r <= 1'b0;
        end else begin
            if (wr_ok && addr == `TPBC_A_CTRL) begin
                ctrl_r[6:0]         <= wdata[6:0];
                ctrl_r[`TPBC_F_RST] <= 1'b0; // R26
            end
            if (ctrl_rd && ctrl_r[`TPBC_F_WFLAG] && clr_allow) wflag_armed_r <= 1'b1; // R19
            if (wrap) begin
                ctrl_r[`TPBC_F_WFLAG] <= 1'b1; // R14
                wflag_armed_r         <= 1'b0;
            end else if (wr_ok && addr == `TPBC_A_CTRL && !wdata[`TPBC_F_WFLAG]
                         && wflag_armed_r && clr_allow) begin
                ctrl_r[`TPBC_F_WFLAG] <= 1'b0; // R19 R20
                wflag_armed_r         <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) limit_r <= `TPBC_LIMIT_RST;
        else if (wr_ok && addr == `TPBC_A_LIMIT) limit_r <= wdata;
    end

    // ----------------------------------------
    // Buffered pair selection
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    last_wr_r[p] <= 1'b0;
                    active_r[p]  <= 1'b0;
                end else begin
                    if (wr_ok && addr == `TPBC_A_CHVAL0 + 5'(2 * p)) last_wr_r[p] <= 1'b0; // R28
                    if (wr_ok && addr == `TPBC_A_CHVAL0 + 5'(2 * p + 1)) last_wr_r[p] <= 1'b1; // R28
                    if (!chctl_r[2 * p][`TPBC_F_MSB]) active_r[p] <= 1'b0; // R3
                    else if (wrap) active_r[p] <= last_wr_r[p]; // R3 R4
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic [3:0] cmp_hit;
    logic [3:0] cap_hit;
    logic [3:0] chrd;
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            localparam int PR = c / 2;
            localparam bit SEC = (c % 2) == 1;
            logic linked_sec;
            logic els_a;
            logic els_b;
            logic edge_hit;
            tpbc_word_t width;
            assign linked_sec = SEC && chctl_r[c - (c % 2)][`TPBC_F_MSB]; // R1 R2 R5
            assign els_a = chctl_r[c][`TPBC_F_ELSA];
            assign els_b = chctl_r[c][`TPBC_F_ELSB];
            assign width = (!SEC && chctl_r[c][`TPBC_F_MSB] && active_r[PR])
                           ? chval_r[c + 1] : chval_r[c]; // R1 R2 R3
            assign cmp_hit[c] = !linked_sec && is_compare(chctl_r[c]) && (els_a | els_b)
                                && tick && (cnt_nxt == width); // R15 R24
            assign edge_hit = (els_a & pin_s2_r[c] & ~pin_prev_r[c])
                            | (els_b & ~pin_s2_r[c] & pin_prev_r[c]);
            assign cap_hit[c] = !linked_sec && !is_compare(chctl_r[c]) && edge_hit; // R24
            assign chrd[c] = rd_ok && addr == `TPBC_A_CHCTL0 + 5'(c);

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    chctl_r[c]       <= 8'h00;
                    cflag_armed_r[c] <= 1'b0;
                end else begin
                    if (wr_ok && addr == `TPBC_A_CHCTL0 + 5'(c) && !linked_sec) begin
                        chctl_r[c][6:0] <= SEC ? {1'b0, wdata[5] & 1'b0, wdata[4:0]} | {2'b00, 5'h00}
                                               : wdata[6:0];
                        if (SEC) chctl_r[c][6] <= wdata[6];
                    end
                    if (chrd[c] && chctl_r[c][`TPBC_F_CFLAG] && clr_allow) cflag_armed_r[c] <= 1'b1;
                    if (cmp_hit[c] || cap_hit[c]) begin
                        chctl_r[c][`TPBC_F_CFLAG] <= 1'b1; // R15
                        cflag_armed_r[c]          <= 1'b0;
                    end else if (wr_ok && addr == `TPBC_A_CHCTL0 + 5'(c) && !linked_sec
                                 && !wdata[`TPBC_F_CFLAG] && cflag_armed_r[c] && clr_allow) begin
                        chctl_r[c][`TPBC_F_CFLAG] <= 1'b0; // R19 R20
                        cflag_armed_r[c]          <= 1'b0;
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) chval_r[c] <= 16'h0000;
                else if (cap_hit[c]) chval_r[c] <= cnt_r;
                else if (wr_ok && addr == `TPBC_A_CHVAL0 + 5'(c)) chval_r[c] <= wdata;
            end

            // Pin level: wrap toggles when TOV is set, compare applies level select
            always_ff @(posedge ref_clk) begin
                if (!rst_n) out_r[c] <= 1'b0;
                else if (!is_compare(chctl_r[c]) || linked_sec) out_r[c] <= 1'b0;
                else if (chctl_r[c][`TPBC_F_MAX] && !chctl_r[c][`TPBC_F_TOV]) begin
                    out_r[c] <= ~els_a; // R13
                end else if (cmp_hit[c]) begin
                    unique case ({els_b, els_a})
                        2'b10:   out_r[c] <= 1'b0; // R9
                        2'b11:   out_r[c] <= 1'b1; // R9
                        default: out_r[c] <= ~out_r[c];
                    endcase
                end else if (wrap && chctl_r[c][`TPBC_F_TOV]) begin
                    out_r[c] <= ~out_r[c]; // R12
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) ch_pin_oe[c] <= 1'b0;
                else ch_pin_oe[c] <= !linked_sec && is_compare(chctl_r[c]) && (els_a | els_b); // R5 R24
            end
        end
    endgenerate

    assign ch_pin_out = out_r;

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_r   <= 4'h0;
            pin_s2_r   <= 4'h0;
            pin_prev_r <= 4'h0;
        end else begin
            pin_s1_r   <= ch_pin_in;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // ----------------------------------------
    // Requests and status outputs
    // ----------------------------------------
    logic [3:0] ch_req;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ch_req[i] = chctl_r[i][`TPBC_F_CFLAG] & chctl_r[i][`TPBC_F_CIE]; // R15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_req          <= 1'b0;
            ext_clk_selected <= 1'b0;
        end else begin
            irq_req <= (ctrl_r[`TPBC_F_WFLAG] & ctrl_r[`TPBC_F_WIE]) | (|ch_req); // R14 R16
            ext_clk_selected <= ext_sel; // R23
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) rdata_r <= 16'h0000;
        else if (rd_ok) begin
            if (addr == `TPBC_A_CTRL) rdata_r <= {8'h00, ctrl_r & 8'hEF}; // R26
            else if (addr == `TPBC_A_CNT) rdata_r <= cnt_r;
            else if (addr == `TPBC_A_LIMIT) rdata_r <= limit_r;
            else if (addr >= `TPBC_A_CHCTL0 && addr < `TPBC_A_CHCTL0 + 5'h04)
                rdata_r <= {8'h00, chctl_r[2'(addr - `TPBC_A_CHCTL0)]};
            else if (addr >= `TPBC_A_CHVAL0 && addr < `TPBC_A_CHVAL0 + 5'h04)
                rdata_r <= chval_r[2'(addr - `TPBC_A_CHVAL0)];
            else if (addr == `TPBC_A_PIN) rdata_r <= {12'h000, out_r};
            else rdata_r <= 16'h0000;
        end else rdata_r <= 16'h0000;
    end
    assign rdata = rdata_r;
endmodule : tpbc_timer
`default_nettype wire

// [tb/tpbc_pin_model.sv]
/*
 Pin-side partner: external count clock and capture pin levels.
 Assumes the bench drives run and lvl on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module tpbc_pin_model (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic [3:0] lvl,
    output logic            ext_clk,
    output logic [3:0]      pins
);
    logic [1:0] div_r = 2'h0;
    // Bus over 4, still outside runs
    always_ff @(posedge ref_clk) begin
        div_r <= run ? div_r + 2'h1 : 2'h0;
    end
    assign ext_clk = run & div_r[1];
    assign pins    = lvl;
endmodule : tpbc_pin_model
`default_nettype wire

// [tb/tpbc_timer_properties.sv]
/*
 Port checker of the timer.
 Assumes binding to tpbc_timer; one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module tpbc_timer_checker (
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic [4:0]           addr,
    input wire tpbc_pkg::tpbc_word_t wdata,
    input wire logic                 wr_stb,
    input wire logic                 rd_stb,
    input wire logic [15:0]          rdata,
    input wire logic                 wait_mode,
    input wire logic                 stop_mode,
    input wire logic                 break_state,
    input wire logic [3:0]           ch_pin_oe,
    input wire logic                 ext_clk_selected
);
    import tpbc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_cnt(f);
        rd_stb && !wait_mode && addr == 5'h01 && f;
    endsequence
    sequence s_wr(a);
        wr_stb && !wait_mode && addr == a;
    endsequence
    property p_wait_rd;
        rd_stb && wait_mode |=> rdata == 16'h0000;
    endproperty
    a_wait_rd: assert property (p_wait_rd) else $error("read served in wait");
    property p_rst_bit;
        rd_stb && !wait_mode && addr == 5'h00 |=> !rdata[4];
    endproperty
    a_rst_bit: assert property (p_rst_bit) else $error("reset bit read one");
    property p_ext_sel;
        s_wr(5'h00) ##0 wdata[2:0] == 3'h7 |-> ##[1:2] ext_clk_selected;
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("ext clock not chosen");
    property p_ext_off;
        s_wr(5'h00) ##0 wdata[2:0] != 3'h7 |-> ##[1:2] !ext_clk_selected;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("ext pin kept");
    property p_pin1;
        s_wr(5'h04) ##0 wdata[5] |-> ##2 !ch_pin_oe[1];
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin 1 still driven");
    property p_pin3;
        s_wr(5'h06) ##0 wdata[5] |-> ##2 !ch_pin_oe[3];
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin 3 still driven");
    property p_stop;
        s_cnt(stop_mode && $past(stop_mode)) ##1 stop_mode ##1 s_cnt(stop_mode)
            |=> rdata == $past(rdata, 2);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved in stop");
    property p_brk;
        s_cnt(break_state && $past(break_state)) ##1 break_state ##1 s_cnt(break_state)
            |=> rdata == $past(rdata, 2);
    endproperty
    a_brk: assert property (p_brk) else $error("counter moved in break");
endmodule : tpbc_timer_checker
bind tpbc_timer tpbc_timer_checker i_tpbc_timer_checker (.ref_clk, .rst_n, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .wait_mode, .stop_mode, .break_state, .ch_pin_oe,
    .ext_clk_selected);
`default_nettype wire

// [tb/tpbc_timer_tb_top.sv]
/*
 Self-checking bench of the timer.
 Assumes the checker is bound and the pin model sits beside the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tpbc_timer_tb_top;
    import tpbc_pkg::*;
    typedef struct packed {logic [4:0] wa; tpbc_word_t wd; logic [4:0] ra; tpbc_word_t ex;} tpbc_row_t;
    localparam tpbc_row_t ROWS [5] = '{
        '{5'h02, 16'h0010, 5'h02, 16'h0010}, '{5'h09, 16'h1234, 5'h09, 16'h1234},
        '{5'h00, 16'h0037, 5'h00, 16'h0027}, '{5'h07, 16'h001A, 5'h07, 16'h001A},
        '{5'h03, 16'h5A5A, 5'h03, 16'h0000}};
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic wait_mode = 1'b0, stop_mode = 1'b0, break_state = 1'b0, bce = 1'b0, run = 1'b0;
    logic [4:0]  addr = 5'h00;
    tpbc_word_t  wdata = 16'h0000, v, u;
    logic [3:0]  lvl = 4'h0, pins, ch_pin_out, ch_pin_oe;
    logic [15:0] rdata;
    logic        ext, ext_clk_selected, irq_req;
    int          num_errors = 0, compares = 0;
    always #10 ref_clk = ~ref_clk;
    tpbc_pin_model i_tpbc_pin_model (.ref_clk(ref_clk), .run(run), .lvl(lvl), .ext_clk(ext),
        .pins(pins));
    tpbc_timer i_tpbc_timer (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_state(break_state), .break_clear_enable(bce),
        .ext_count_clock_pin(ext), .ch_pin_in(pins), .ch_pin_out(ch_pin_out),
        .ch_pin_oe(ch_pin_oe), .ext_clk_selected(ext_clk_selected), .irq_req(irq_req));
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input tpbc_word_t d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output tpbc_word_t d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic highs(input int b, input logic [15:0] e);
        logic [15:0] n;
        n = 16'h0000;
        repeat (30) @(posedge ref_clk);
        repeat (40) begin
            @(posedge ref_clk);
            #1 n = n + 16'(ch_pin_out[b]);
        end
        chk(n, e);
    endtask : highs
    task automatic do_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic freeze(input logic s);
        stop_mode <= s;
        break_state <= !s;
        repeat (3) @(posedge ref_clk);
        rd(5'h01, u);
        rd(5'h01, v);
        chk(v, u);
        stop_mode <= 1'b0;
        break_state <= 1'b0;
    endtask : freeze
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            wr(ROWS[i].wa, ROWS[i].wd);
            rd(ROWS[i].ra, v);
            chk(v, ROWS[i].ex);
        end
        do_reset();
        rd(5'h00, v);
        chk(v, 16'h0020);
        rd(5'h02, v);
        chk(v, 16'hFFFF);
        wr(5'h07, 16'h0044);
        lvl <= 4'h8;
        repeat (6) @(posedge ref_clk);
        rd(5'h07, v);
        chk(v, 16'h00C4);
        chk(16'(irq_req), 16'h0001);
        wr(5'h07, 16'h0004);
        repeat (3) @(posedge ref_clk);
        chk(16'(irq_req), 16'h0000);
        for (int ps = 0; ps < 7; ps++) begin
            wr(5'h00, 16'h0030 | 16'(ps));
            rd(5'h01, v);
            chk(v, 16'h0000);
            wr(5'h00, 16'(ps));
            repeat (128) @(posedge ref_clk);
            rd(5'h01, v);
            chk(16'(v - (16'h0080 >> ps) <= 16'h0004), 16'h0001);
        end
        wr(5'h00, 16'h0030);
        wr(5'h02, 16'h0009);
        wr(5'h08, 16'h0004);
        wr(5'h04, 16'h001A);
        wr(5'h00, 16'h0000);
        highs(0, 16'h0010);
        chk(16'(ch_pin_oe[0]), 16'h0001);
        rd(5'h00, v);
        chk(v & 16'h0080, 16'h0080);
        chk(16'(irq_req), 16'h0000);
        wr(5'h00, 16'h0040);
        repeat (12) @(posedge ref_clk);
        chk(16'(irq_req), 16'h0001);
        wr(5'h04, 16'h0018);
        highs(0, 16'h0000);
        wr(5'h04, 16'h0019);
        highs(0, 16'h0028);
        freeze(1'b1);
        freeze(1'b0);
        break_state <= 1'b1;
        rd(5'h00, v);
        wr(5'h00, 16'h0040);
        rd(5'h00, v);
        chk(v & 16'h0080, 16'h0080);
        bce <= 1'b1;
        rd(5'h00, v);
        wr(5'h00, 16'h0020);
        rd(5'h00, v);
        chk(v, 16'h0020);
        break_state <= 1'b0;
        rd(5'h00, v);
        chk(v, 16'h0020);
        wait_mode <= 1'b1;
        wr(5'h02, 16'h0005);
        rd(5'h02, v);
        chk(v, 16'h0000);
        wait_mode <= 1'b0;
        rd(5'h02, v);
        chk(v, 16'h0009);
        for (int p = 0; p < 4; p += 2) begin
            wr(5'h00, 16'h0030);
            wr(5'(8 + p), 16'h0004);
            wr(5'(4 + p), 16'h003A);
            wr(5'h00, 16'h0000);
            highs(p, 16'h0010);
            chk(16'(ch_pin_oe[p + 1]), 16'h0000);
            wr(5'(9 + p), 16'h0007);
            highs(p, 16'h001C);
            wr(5'(8 + p), 16'h0002);
            highs(p, 16'h0008);
        end
        wr(5'h00, 16'h0007);
        repeat (10) @(posedge ref_clk);
        rd(5'h01, u);
        repeat (10) @(posedge ref_clk);
        rd(5'h01, v);
        chk(v, u);
        chk(16'(ext_clk_selected), 16'h0001);
        run <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rd(5'h01, v);
        chk(16'(v != u), 16'h0001);
        run <= 1'b0;
        wr(5'h00, 16'h0020);
        repeat (2) @(posedge ref_clk);
        chk(16'(ext_clk_selected), 16'h0000);
        wrap_up();
    end
endmodule : tpbc_timer_tb_top
`default_nettype wire
